// File: fault_action_ctrl.sv
// one fault-response sequencer: ignore, delay, disable-and-retry, resume-when-ok
`timescale 1ns/1ps
module fault_action_ctrl #(
    parameter int DELAY_UNIT_CYCLES = temp_sup_pkg::DELAY_UNIT_CYCLES,
    parameter int RETRY_UNIT_CYCLES = temp_sup_pkg::RETRY_UNIT_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic fault_i,
    input wire logic clear_i,
    input wire logic [7:0] action_i,
    output logic run_o
);
    temp_sup_pkg::action_state_t state_r, state_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [2:0] tries_r, tries_nxt;

    wire [1:0] resp = action_i[temp_sup_pkg::RESP_HI:temp_sup_pkg::RESP_LO];
    wire [2:0] retries = action_i[temp_sup_pkg::RETRY_HI:temp_sup_pkg::RETRY_LO];
    wire [2:0] dcode = action_i[temp_sup_pkg::DELAY_HI:temp_sup_pkg::DELAY_LO];
    // binary weighted units, code n gives 2**n units (see RL10)
    wire [31:0] units = 32'h1 << dcode;
    // same weight used for the run-on delay and the restart spacing (see RL11)
    wire [31:0] delay_load = 32'(units * 32'(DELAY_UNIT_CYCLES)) - 32'h1;
    wire [31:0] space_load = 32'(units * 32'(RETRY_UNIT_CYCLES)) - 32'h1;
    wire expired = (cnt_r == 32'h0);
    wire last_try = ((tries_r + 3'h1) >= retries);

    // next state; counter counts down in every state until it reaches zero, then holds
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r != 32'h0) ? cnt_r - 32'h1 : cnt_r;
        tries_nxt = tries_r;
        case (state_r)
            temp_sup_pkg::ST_RUN: begin
                tries_nxt = 3'h0;
                if (fault_i) begin
                    case (resp)
                        temp_sup_pkg::RESP_DELAY: begin
                            state_nxt = temp_sup_pkg::ST_DELAY; // see RL6
                            cnt_nxt = delay_load;
                        end
                        temp_sup_pkg::RESP_DISABLE: begin
                            // no retries means latch off (see RL7) (see RL9)
                            state_nxt = (retries == 3'h0) ? temp_sup_pkg::ST_LOCKED
                                                          : temp_sup_pkg::ST_SPACING;
                            cnt_nxt = space_load;
                        end
                        temp_sup_pkg::RESP_RESUME: state_nxt = temp_sup_pkg::ST_HOLD;
                        default: state_nxt = temp_sup_pkg::ST_RUN; // see RL5
                    endcase
                end
            end
            temp_sup_pkg::ST_DELAY: begin
                if (!fault_i) begin
                    state_nxt = temp_sup_pkg::ST_RUN;
                end else if (expired) begin
                    // fault outlived the delay: act by retry field (see RL6)
                    state_nxt = (retries == 3'h0) ? temp_sup_pkg::ST_LOCKED
                                                  : temp_sup_pkg::ST_SPACING;
                    cnt_nxt = space_load;
                end
            end
            temp_sup_pkg::ST_SPACING: begin
                if (expired) begin
                    // restart attempt; give up after the programmed count (see RL13)
                    tries_nxt = tries_r + 3'h1;
                    if (!fault_i) begin
                        state_nxt = temp_sup_pkg::ST_RUN;
                    end else if (last_try) begin
                        state_nxt = temp_sup_pkg::ST_LOCKED;
                    end else begin
                        cnt_nxt = space_load;
                    end
                end
            end
            temp_sup_pkg::ST_LOCKED: begin
                if (clear_i) begin
                    state_nxt = temp_sup_pkg::ST_RUN; // see RL9
                end
            end
            temp_sup_pkg::ST_HOLD: begin
                if (!fault_i) begin
                    state_nxt = temp_sup_pkg::ST_RUN; // see RL8
                end
            end
            default: state_nxt = temp_sup_pkg::ST_RUN;
        endcase
    end

    wire run_nxt = (state_nxt == temp_sup_pkg::ST_RUN) || (state_nxt == temp_sup_pkg::ST_DELAY);

    // state registers, frozen while the clock enable is low
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= temp_sup_pkg::ST_RUN;
            cnt_r <= 32'h0;
            tries_r <= 3'h0;
            run_o <= 1'b1;
        end else if (ce_i) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            tries_r <= tries_nxt;
            run_o <= run_nxt;
        end
    end

    property p_ignore_runs;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && state_r == temp_sup_pkg::ST_RUN && resp == temp_sup_pkg::RESP_IGNORE |=> run_o;
    endproperty
    a_ignore_runs: assert property (p_ignore_runs) // see RL5
        else $error("ignore mode stopped output");

    property p_delay_keeps_running;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && state_r == temp_sup_pkg::ST_RUN && fault_i && resp == temp_sup_pkg::RESP_DELAY
            |=> run_o && cnt_r == $past(delay_load);
    endproperty
    a_delay_keeps_running: assert property (p_delay_keeps_running) // see RL6
        else $error("delay mode wrong");

    property p_disable_now;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && state_r == temp_sup_pkg::ST_RUN && fault_i && resp == temp_sup_pkg::RESP_DISABLE
            |=> !run_o;
    endproperty
    a_disable_now: assert property (p_disable_now) // see RL7
        else $error("disable mode kept output on");

    property p_resume_ok;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && state_r == temp_sup_pkg::ST_HOLD && !fault_i |=> run_o;
    endproperty
    a_resume_ok: assert property (p_resume_ok) // see RL8
        else $error("no resume after fault gone");

    property p_latched;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && state_r == temp_sup_pkg::ST_LOCKED && !clear_i |=> !run_o && $stable(state_r);
    endproperty
    a_latched: assert property (p_latched) else $error("latched off state left"); // see RL9

    property p_units;
        @(posedge clock_i) disable iff (rst_i)
        // a wrong decode would load a run-on longer than 128 units
        state_r == temp_sup_pkg::ST_DELAY |-> cnt_r <= 32'(128 * DELAY_UNIT_CYCLES) - 32'h1;
    endproperty
    a_units: assert property (p_units) else $error("delay code decode wrong"); // see RL10

    property p_spacing_reload;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && state_r == temp_sup_pkg::ST_SPACING && expired && fault_i && !last_try
            |=> cnt_r == $past(space_load) && !run_o;
    endproperty
    a_spacing_reload: assert property (p_spacing_reload) // see RL11
        else $error("retry spacing wrong");

    property p_try_limit;
        @(posedge clock_i) disable iff (rst_i)
        state_r == temp_sup_pkg::ST_SPACING |-> tries_r < retries;
    endproperty
    a_try_limit: assert property (p_try_limit) // see RL13
        else $error("too many restart attempts");
endmodule

// File: mgmt_host.sv
// management host model that drives the supervisor's register port
`timescale 1ns/1ps
module mgmt_host (
    input wire logic clock_i,
    input wire logic [15:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_cmd_o,
    output logic [15:0] reg_wdata_o
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_cmd_o = 8'h00;
        reg_wdata_o = 16'h0000;
    end

    // invert idle bus so a stale command or word never passes as a fresh one
    task automatic release_bus;
        reg_cmd_o = ~reg_cmd_o;
        reg_wdata_o = ~reg_wdata_o;
    endtask

    // one whole word per write; action bytes ride in the low byte
    task automatic write(input logic [7:0] cmd, input logic [15:0] data);
        @(negedge clock_i);
        reg_cmd_o = cmd;
        reg_wdata_o = data;
        reg_wr_o = 1'b1;
        @(negedge clock_i);
        reg_wr_o = 1'b0;
        release_bus();
    endtask

    // strobe held over one rising edge, answer awaited under a short bound
    task automatic read(input logic [7:0] cmd, output logic [15:0] data);
        int n;
        @(negedge clock_i);
        reg_cmd_o = cmd;
        reg_rd_o = 1'b1;
        @(negedge clock_i);
        reg_rd_o = 1'b0;
        release_bus();
        n = 0;
        while (reg_rvalid_i !== 1'b1 && n < 2) begin
            @(negedge clock_i);
            n++;
        end
        data = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 16'hxxxx;
    endtask
endmodule

// File: temp_fault_supervisor.sv
// temperature thresholds, fault responses and alert for the converter
`timescale 1ns/1ps
// Functional notes
// RL1: hold 16-bit linear over-temperature fault threshold; compare temperature against it.
// RL2: hold separate 16-bit linear over-temperature warning threshold.
// RL3: hold 16-bit linear under-temperature warning threshold.
// RL4: hold 16-bit under-temperature fault threshold with its own action byte.
// RL5: response 00 keeps the output running through the fault.
// RL6: response 01 runs on for the delay, then acts by retry field.
// RL7: response 10 disables output at once, then follows retry field.
// RL8: response 11 holds output off while fault lasts, resumes after.
// RL9: retry field 000 means no restart; output stays off until cleared.
// RL10: delay code n means 2**n time units, 1 to 128.
// RL11: decoded delay sets run-on time and restart spacing; unit set elsewhere.
// RL12: every response mode pulls alert low and sets the matching status bit.
// RL13: nonzero retry field allows that many restart attempts before giving up.
// RL14: over at or above threshold, under at or below; warnings never stop output.
// RL15: host writes thresholds as words, actions as bytes, reads them back unchanged.
module temp_fault_supervisor #(
    parameter int DELAY_UNIT_CYCLES = temp_sup_pkg::DELAY_UNIT_CYCLES,
    parameter int RETRY_UNIT_CYCLES = temp_sup_pkg::RETRY_UNIT_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_cmd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic [15:0] temp_i,
    input wire logic fault_clear_i,
    output logic output_enable_o,
    output logic alert_output_n_o,
    output temp_sup_pkg::temp_flags_t status_o
);
    // linear word to signed fixed point with 16 fraction bits
    function automatic logic signed [47:0] lin_to_fix(input logic [15:0] w);
        logic signed [47:0] m;
        logic [4:0] sh;
        m = {{37{w[temp_sup_pkg::LIN_MANT_HI]}}, w[temp_sup_pkg::LIN_MANT_HI:0]};
        sh = 5'(w[15:temp_sup_pkg::LIN_EXP_LO] + 5'(temp_sup_pkg::LIN_FRAC_BITS));
        return m <<< sh;
    endfunction

    logic [15:0] ot_fault_thr_r, ot_warn_thr_r, ut_warn_thr_r, ut_fault_thr_r;
    logic [7:0] ot_act_r, ut_act_r;
    logic run_ot, run_ut;
    temp_sup_pkg::temp_flags_t det, status_nxt;

    // threshold compares, both ends inclusive (see RL14)
    wire signed [47:0] temp_fix = lin_to_fix(temp_i);
    assign det.ot_fault = temp_fix >= lin_to_fix(ot_fault_thr_r); // see RL1
    assign det.ot_warn = temp_fix >= lin_to_fix(ot_warn_thr_r); // see RL2
    assign det.ut_warn = temp_fix <= lin_to_fix(ut_warn_thr_r); // see RL3
    assign det.ut_fault = temp_fix <= lin_to_fix(ut_fault_thr_r); // see RL4

    // sticky status: a new detection wins over a clear in the same cycle (see RL12)
    assign status_nxt = fault_clear_i ? det : (status_o | det);

    // write decode per command code
    wire wr_otf = reg_wr_i && reg_cmd_i == temp_sup_pkg::CMD_OT_FAULT_THR;
    wire wr_ota = reg_wr_i && reg_cmd_i == temp_sup_pkg::CMD_OT_FAULT_ACT;
    wire wr_otw = reg_wr_i && reg_cmd_i == temp_sup_pkg::CMD_OT_WARN_THR;
    wire wr_utw = reg_wr_i && reg_cmd_i == temp_sup_pkg::CMD_UT_WARN_THR;
    wire wr_utf = reg_wr_i && reg_cmd_i == temp_sup_pkg::CMD_UT_FAULT_THR;
    wire wr_uta = reg_wr_i && reg_cmd_i == temp_sup_pkg::CMD_UT_FAULT_ACT;

    // read mux; unmapped codes read zero, action bytes in the low lane
    logic [15:0] rd_sel;
    always_comb begin
        case (reg_cmd_i)
            temp_sup_pkg::CMD_OT_FAULT_THR: rd_sel = ot_fault_thr_r;
            temp_sup_pkg::CMD_OT_FAULT_ACT: rd_sel = {8'h00, ot_act_r};
            temp_sup_pkg::CMD_OT_WARN_THR: rd_sel = ot_warn_thr_r;
            temp_sup_pkg::CMD_UT_WARN_THR: rd_sel = ut_warn_thr_r;
            temp_sup_pkg::CMD_UT_FAULT_THR: rd_sel = ut_fault_thr_r;
            temp_sup_pkg::CMD_UT_FAULT_ACT: rd_sel = {8'h00, ut_act_r};
            default: rd_sel = 16'h0000;
        endcase
    end

    // register file; actions keep only the low byte (see RL15)
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ot_fault_thr_r <= temp_sup_pkg::RST_OT_FAULT_THR;
            ot_warn_thr_r <= temp_sup_pkg::RST_OT_WARN_THR;
            ut_warn_thr_r <= temp_sup_pkg::RST_UT_WARN_THR;
            ut_fault_thr_r <= temp_sup_pkg::RST_UT_FAULT_THR;
            ot_act_r <= temp_sup_pkg::RST_FAULT_ACT;
            ut_act_r <= temp_sup_pkg::RST_FAULT_ACT;
        end else if (ce_i) begin
            if (wr_otf) ot_fault_thr_r <= reg_wdata_i;
            if (wr_otw) ot_warn_thr_r <= reg_wdata_i;
            if (wr_utw) ut_warn_thr_r <= reg_wdata_i;
            if (wr_utf) ut_fault_thr_r <= reg_wdata_i;
            if (wr_ota) ot_act_r <= reg_wdata_i[7:0];
            if (wr_uta) ut_act_r <= reg_wdata_i[7:0];
        end
    end

    // outputs all registered; warnings feed only status and alert (see RL14)
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
            reg_rvalid_o <= 1'b0;
            status_o <= '0;
            alert_output_n_o <= 1'b1;
            output_enable_o <= 1'b1;
        end else if (ce_i) begin
            reg_rdata_o <= reg_rd_i ? rd_sel : reg_rdata_o;
            reg_rvalid_o <= reg_rd_i;
            status_o <= status_nxt;
            alert_output_n_o <= ~(|status_nxt); // see RL12
            output_enable_o <= run_ot & run_ut;
        end
    end

    // separate sequencers so each fault keeps its own action byte (see RL4)
    fault_action_ctrl #(
        .DELAY_UNIT_CYCLES(DELAY_UNIT_CYCLES),
        .RETRY_UNIT_CYCLES(RETRY_UNIT_CYCLES)
    ) u_ot_action (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .fault_i(det.ot_fault),
        .clear_i(fault_clear_i),
        .action_i(ot_act_r),
        .run_o(run_ot)
    );

    fault_action_ctrl #(
        .DELAY_UNIT_CYCLES(DELAY_UNIT_CYCLES),
        .RETRY_UNIT_CYCLES(RETRY_UNIT_CYCLES)
    ) u_ut_action (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .fault_i(det.ut_fault),
        .clear_i(fault_clear_i),
        .action_i(ut_act_r),
        .run_o(run_ut)
    );

    property p_ot_fault_flag;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && det.ot_fault |=> status_o.ot_fault && !alert_output_n_o;
    endproperty
    a_ot_fault_flag: assert property (p_ot_fault_flag) // see RL1
        else $error("ot fault not flagged");

    property p_ot_warn_flag;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && det.ot_warn |=> status_o.ot_warn;
    endproperty
    a_ot_warn_flag: assert property (p_ot_warn_flag) // see RL2
        else $error("ot warning not flagged");

    property p_ut_warn_flag;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && det.ut_warn |=> status_o.ut_warn;
    endproperty
    a_ut_warn_flag: assert property (p_ut_warn_flag) // see RL3
        else $error("ut warning not flagged");

    property p_ut_act_write;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && wr_uta |=> ut_act_r == $past(reg_wdata_i[7:0]) && ot_act_r == $past(ot_act_r);
    endproperty
    a_ut_act_write: assert property (p_ut_act_write) // see RL4
        else $error("ut action write wrong");

    property p_alert_sticky;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && (|status_o) && !fault_clear_i |=> !alert_output_n_o;
    endproperty
    a_alert_sticky: assert property (p_alert_sticky) // see RL12
        else $error("alert released early");

    property p_warn_no_stop;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && !det.ot_fault && !det.ut_fault && run_ot && run_ut |=> output_enable_o;
    endproperty
    a_warn_no_stop: assert property (p_warn_no_stop) // see RL14
        else $error("output stopped without fault");

    property p_ut_fault_flag;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && det.ut_fault |=> status_o.ut_fault && !alert_output_n_o;
    endproperty
    a_ut_fault_flag: assert property (p_ut_fault_flag) // see RL4
        else $error("ut fault not flagged");

    // a clear only lets go of the alert once every condition has gone
    property p_clear_releases;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && fault_clear_i && det == 4'h0 |=> status_o == 4'h0 && alert_output_n_o;
    endproperty
    a_clear_releases: assert property (p_clear_releases) // see RL12
        else $error("clear did not release status");

    property p_read_answer;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && reg_rd_i |=> reg_rvalid_o && reg_rdata_o == $past(rd_sel);
    endproperty
    a_read_answer: assert property (p_read_answer) // see RL15
        else $error("read answer wrong");

    property p_thr_write;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && wr_otf |=> ot_fault_thr_r == $past(reg_wdata_i);
    endproperty
    a_thr_write: assert property (p_thr_write) // see RL1
        else $error("fault threshold write lost");

    // enable low must hold the flags, so a paused core never drops an alert
    property p_freeze;
        @(posedge clock_i) disable iff (rst_i)
        !ce_i |=> $stable(status_o) && $stable(output_enable_o) && $stable(alert_output_n_o);
    endproperty
    a_freeze: assert property (p_freeze) // see RL12
        else $error("outputs moved while enable low");

    property p_oe_follows;
        @(posedge clock_i) disable iff (rst_i)
        ce_i && !(run_ot && run_ut) |=> !output_enable_o;
    endproperty
    a_oe_follows: assert property (p_oe_follows) // see RL8
        else $error("output kept on while a sequencer is off");
endmodule

// File: temp_fault_supervisor_tb.sv
// self-checking bench for the temperature fault supervisor
`timescale 1ns/1ps
module temp_fault_supervisor_tb;
    localparam int DU = 4;
    localparam int RU = 3;
    localparam logic [15:0] T_NORM = 16'h0019;
    localparam logic [15:0] T_HOT = 16'h007d;
    localparam logic [15:0] T_WARM = 16'h0078;
    localparam logic [15:0] T_CHILLY = 16'h07dd;
    localparam logic [15:0] T_COLD = 16'h07d8;

    logic clock, rst, ce, wr, rd, rvalid, fault_clear, oe, alert_n;
    logic [7:0] cmd;
    logic [15:0] wdata, rdata, temp;
    temp_sup_pkg::temp_flags_t status;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;

    temp_fault_supervisor #(.DELAY_UNIT_CYCLES(DU), .RETRY_UNIT_CYCLES(RU))
        u_temp_fault_supervisor (
        .clock_i(clock), .rst_i(rst), .ce_i(ce), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_cmd_i(cmd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .temp_i(temp), .fault_clear_i(fault_clear), .output_enable_o(oe),
        .alert_output_n_o(alert_n), .status_o(status));

    mgmt_host u_mgmt_host (.clock_i(clock), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_cmd_o(cmd), .reg_wdata_o(wdata));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // hang guard; longest scenario is the 512-cycle delay
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic conclude;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    // alert must track the sticky flags; output enable checked beside them
    task automatic pins(input logic [3:0] st, input logic o);
        chk({11'h000, alert_n, status}, {11'h000, st == 4'h0, st});
        chk({15'h0000, oe}, {15'h0000, o});
    endtask

    // back to a cool part and wipe the sticky flags and latches
    task automatic recover;
        temp = T_NORM;
        cyc(2);
        fault_clear = 1'b1;
        cyc(1);
        fault_clear = 1'b0;
        cyc(3);
    endtask

    task automatic t_regs;
        logic [15:0] d;
        u_mgmt_host.read(temp_sup_pkg::CMD_OT_FAULT_THR, d);
        chk(d, 16'h007d);
        u_mgmt_host.read(temp_sup_pkg::CMD_OT_WARN_THR, d);
        chk(d, 16'h0073);
        u_mgmt_host.read(temp_sup_pkg::CMD_UT_WARN_THR, d);
        chk(d, 16'h07e2);
        u_mgmt_host.read(temp_sup_pkg::CMD_UT_FAULT_THR, d);
        chk(d, 16'h07d8);
        u_mgmt_host.read(temp_sup_pkg::CMD_UT_FAULT_ACT, d);
        chk(d, 16'h00c0);
        u_mgmt_host.write(8'h55, 16'h1234);
        u_mgmt_host.read(8'h55, d);
        chk(d, 16'h0000);
        u_mgmt_host.write(temp_sup_pkg::CMD_OT_WARN_THR, 16'h0074);
        u_mgmt_host.read(temp_sup_pkg::CMD_OT_WARN_THR, d);
        chk(d, 16'h0074);
        u_mgmt_host.write(temp_sup_pkg::CMD_OT_FAULT_ACT, 16'hab48);
        u_mgmt_host.read(temp_sup_pkg::CMD_OT_FAULT_ACT, d);
        chk(d, 16'h0048);
    endtask

    // a fault exactly at the threshold under a given action, then recovery
    task automatic t_ignore;
        u_mgmt_host.write(temp_sup_pkg::CMD_OT_FAULT_ACT, 16'h0000);
        temp = T_HOT;
        cyc(3);
        pins(4'h3, 1'b1);
        cyc(20);
        pins(4'h3, 1'b1);
        recover();
        pins(4'h0, 1'b1);
    endtask

    task automatic t_resume;
        u_mgmt_host.write(temp_sup_pkg::CMD_OT_FAULT_ACT, 16'h00c0);
        temp = T_HOT;
        cyc(4);
        pins(4'h3, 1'b0);
        temp = T_NORM;
        cyc(4);
        pins(4'h3, 1'b1);
        recover();
    endtask

    task automatic t_latch;
        u_mgmt_host.write(temp_sup_pkg::CMD_OT_FAULT_ACT, 16'h0080);
        temp = T_HOT;
        cyc(4);
        pins(4'h3, 1'b0);
        temp = T_NORM;
        cyc(20);
        pins(4'h3, 1'b0);
        recover();
        pins(4'h0, 1'b1);
    endtask

    // one attempt: first a brief fault that recovers, then one that outlasts it
    task automatic t_retry;
        u_mgmt_host.write(temp_sup_pkg::CMD_OT_FAULT_ACT, 16'h0088);
        temp = T_HOT;
        // attempt falls three cycles after shutdown; the fault must be gone by then
        cyc(3);
        chk({15'h0000, oe}, 16'h0000);
        temp = T_NORM;
        cyc(RU + 6);
        chk({15'h0000, oe}, 16'h0001);
        recover();
        temp = T_HOT;
        cyc(4 * RU + 10);
        temp = T_NORM;
        cyc(10);
        chk({15'h0000, oe}, 16'h0000);
        recover();
    endtask

    // run-on time is two to the code times the unit, then off with no retry
    task automatic t_delay(input logic [2:0] code);
        int units;
        units = 1 << code;
        u_mgmt_host.write(temp_sup_pkg::CMD_OT_FAULT_ACT, {13'h0008, code});
        temp = T_HOT;
        // still on in the last run-on cycle, off exactly one cycle later
        cyc(units * DU + 1);
        chk({15'h0000, oe}, 16'h0001);
        cyc(1);
        chk({15'h0000, oe}, 16'h0000);
        recover();
    endtask

    // enable low freezes flags and output although the part is hot
    task automatic t_freeze;
        ce = 1'b0;
        temp = T_HOT;
        cyc(6);
        pins(4'h0, 1'b1);
        ce = 1'b1;
        cyc(3);
        pins(4'h3, 1'b1);
        recover();
    endtask

    task automatic t_warn;
        temp = T_WARM;
        cyc(3);
        pins(4'h2, 1'b1);
        recover();
        temp = T_CHILLY;
        cyc(3);
        pins(4'h4, 1'b1);
        temp = T_COLD;
        cyc(4);
        pins(4'hc, 1'b0);
        recover();
        pins(4'h0, 1'b1);
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        temp = T_NORM;
        fault_clear = 1'b0;
        cyc(2);
        rst = 1'b0;
        pins(4'h0, 1'b1);
        t_regs();
        t_ignore();
        t_resume();
        t_latch();
        t_retry();
        t_delay(3'h0);
        t_delay(3'h1);
        t_delay(3'h7);
        t_freeze();
        t_warn();
        conclude();
    end
endmodule

// File: temp_sup_pkg.sv
// shared constants and types for the temperature fault supervisor
package temp_sup_pkg;
    // command codes of the six registers
    localparam logic [7:0] CMD_OT_FAULT_THR = 8'h4f;
    localparam logic [7:0] CMD_OT_FAULT_ACT = 8'h50;
    localparam logic [7:0] CMD_OT_WARN_THR = 8'h51;
    localparam logic [7:0] CMD_UT_WARN_THR = 8'h52;
    localparam logic [7:0] CMD_UT_FAULT_THR = 8'h53;
    localparam logic [7:0] CMD_UT_FAULT_ACT = 8'h54;
    // reset values, thresholds in linear format with exponent zero
    localparam logic [15:0] RST_OT_FAULT_THR = 16'h007d;
    localparam logic [15:0] RST_OT_WARN_THR = 16'h0073;
    localparam logic [15:0] RST_UT_WARN_THR = 16'h07e2;
    localparam logic [15:0] RST_UT_FAULT_THR = 16'h07d8;
    localparam logic [7:0] RST_FAULT_ACT = 8'hc0;
    // action byte fields
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_DELAY = 2'h1;
    localparam logic [1:0] RESP_DISABLE = 2'h2;
    localparam logic [1:0] RESP_RESUME = 2'h3;
    // linear format fields
    localparam int LIN_EXP_LO = 11;
    localparam int LIN_MANT_HI = 10;
    localparam int LIN_FRAC_BITS = 16;
    // time units
    localparam int CLK_MHZ = 125;
    localparam int DELAY_UNIT_US = 10000;
    localparam int RETRY_UNIT_US = 8200;
    localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_US * CLK_MHZ;
    localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_US * CLK_MHZ;

    typedef struct packed {
        logic ut_fault;
        logic ut_warn;
        logic ot_warn;
        logic ot_fault;
    } temp_flags_t;

    typedef enum logic [4:0] {
        ST_RUN = 5'b00001,
        ST_DELAY = 5'b00010,
        ST_SPACING = 5'b00100,
        ST_LOCKED = 5'b01000,
        ST_HOLD = 5'b10000
    } action_state_t;
endpackage
